// ### rtl/fsa_pkg.sv
// constants and types for the flash sector access and protection block
package fsa_pkg;
   // array layout
   localparam int unsigned FSA_FLASH_BYTES = 16384;
   localparam int unsigned FSA_SEC_BYTES   = 4096;
   localparam int          FSA_IDX_W       = 14;
   localparam int unsigned FSA_SECTORS     = (FSA_FLASH_BYTES <= 4096) ? 1 :
                                             (FSA_FLASH_BYTES <= 8192) ? 2 : 3;
   localparam logic [15:0] FSA_FLASH_BASE  = 16'(32'h10000 - FSA_FLASH_BYTES);
   localparam logic [3:0]  FSA_SEC0_TOP    = 4'hF;
   localparam logic [3:0]  FSA_SEC1_TOP    = 4'hE;
   localparam logic [13:0] FSA_S0_LO = 14'(FSA_FLASH_BYTES - FSA_SEC_BYTES);
   localparam logic [13:0] FSA_S0_HI = 14'(FSA_FLASH_BYTES - 1);
   localparam logic [13:0] FSA_S1_LO = 14'(FSA_FLASH_BYTES - 2 * FSA_SEC_BYTES);
   localparam logic [13:0] FSA_S1_HI = 14'(FSA_FLASH_BYTES - FSA_SEC_BYTES - 1);
   localparam logic [13:0] FSA_S2_LO = 14'h0000;
   localparam logic [13:0] FSA_S2_HI = 14'(FSA_FLASH_BYTES - 2 * FSA_SEC_BYTES - 1);
   localparam logic [7:0]  FSA_ERASED = 8'hFF;
   // register map, byte addresses
   localparam int          FSA_AW         = 8;
   localparam logic [7:0]  FSA_CTRL_OFS   = 8'h38;
   localparam logic [7:0]  FSA_ADDR_OFS   = 8'h3C;
   localparam logic [7:0]  FSA_WDATA_OFS  = 8'h40;
   localparam logic [7:0]  FSA_RDATA_OFS  = 8'h44;
   localparam logic [7:0]  FSA_STAT_OFS   = 8'h48;
   localparam logic [7:0]  FSA_OPT_OFS    = 8'h4C;
   // control register fields
   localparam int          FSA_CTRL_PROG   = 0;
   localparam int          FSA_CTRL_SERASE = 1;
   localparam int          FSA_CTRL_MERASE = 2;
   localparam int          FSA_CTRL_OPTW   = 3;
   localparam int          FSA_CTRL_SEL    = 4;
   localparam int          FSA_CTRL_BUSY   = 7;
   localparam logic [7:0]  FSA_CTRL_RST    = 8'h00;
   // option byte and status fields
   localparam logic [7:0]  FSA_OPT_RST     = 8'h00;
   localparam int          FSA_OPT_PROT    = 0;
   localparam int          FSA_STS_BUSY    = 0;
   localparam int          FSA_STS_REFUSED = 1;
   localparam int          FSA_STS_PROT    = 2;
   localparam int          FSA_STS_MODE    = 3;
   // bus responses
   localparam logic [1:0]  FSA_RESP_OKAY   = 2'b00;
   localparam logic [1:0]  FSA_RESP_SLVERR = 2'b10;
   // link command bytes
   localparam logic [7:0]  FSA_LK_PROG   = 8'h01;
   localparam logic [7:0]  FSA_LK_READ   = 8'h02;
   localparam logic [7:0]  FSA_LK_SERASE = 8'h03;
   localparam logic [7:0]  FSA_LK_MERASE = 8'h04;
   localparam logic [7:0]  FSA_LK_OPTW   = 8'h05;
   // mode codes as shown in status
   localparam logic [1:0]  FSA_MODE_APP    = 2'd0;
   localparam logic [1:0]  FSA_MODE_INCIRC = 2'd1;
   localparam logic [1:0]  FSA_MODE_SOCKET = 2'd2;

   typedef enum {FSA_OP_NONE, FSA_OP_PROG, FSA_OP_SERASE, FSA_OP_MERASE,
                 FSA_OP_OPTW} fsa_op_t;
   typedef enum {FSA_ENG_IDLE, FSA_ENG_ERASE} fsa_state_t;
endpackage

// ### rtl/fsa_link_shifter.sv
// serial link shifter: samples the tool clock, shifts bytes in and out
`timescale 1ns/1ps
module fsa_link_shifter
   import fsa_pkg::*;
(
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_reset_n,
   // link pins
   input  wire logic       i_enable,
   input  wire logic       i_sclk_pin,
   input  wire logic       i_sdata_pin,
   output logic            o_sdata,
   output logic            o_sdata_oe,
   // byte side
   input  wire logic       i_tx_load,
   input  wire logic [7:0] i_tx_byte,
   output logic [7:0]      o_rx_byte,
   output logic            o_rx_valid
);
   logic [2:0] clk_sync;
   logic [1:0] dat_sync;
   logic [6:0] rx_sh;
   logic [2:0] rx_cnt;
   logic [7:0] tx_sh;
   logic [3:0] tx_cnt;
   logic       tx_armed;
   wire        clk_rise = clk_sync[1] & ~clk_sync[2];
   wire        clk_fall = ~clk_sync[1] & clk_sync[2];

   // pins are asynchronous to the core clock: two flops before any use
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         clk_sync <= 3'h0;
         dat_sync <= 2'h0;
      end else begin
         clk_sync <= {clk_sync[1:0], i_sclk_pin};
         dat_sync <= {dat_sync[0], i_sdata_pin};
      end
   end

   // tool clock rising edge samples data, msb first
   always_ff @(posedge i_mclk) begin
      o_rx_valid <= 1'b0;
      if (!i_reset_n || !i_enable) begin
         rx_sh     <= 7'h00;
         rx_cnt    <= 3'h0;
         o_rx_byte <= 8'h00;
      end else if (clk_rise) begin
         rx_sh  <= {rx_sh[5:0], dat_sync[1]};
         rx_cnt <= rx_cnt + 3'h1;
         if (rx_cnt == 3'h7) begin
            o_rx_byte  <= {rx_sh, dat_sync[1]};
            o_rx_valid <= 1'b1;
         end
      end
   end

   // answer bits change on falling edges, only after the first rising one,
   // so a falling edge that trails the request byte cannot skip a bit
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n || !i_enable) begin
         tx_sh    <= 8'h00;
         tx_cnt   <= 4'h0;
         tx_armed <= 1'b0;
         o_sdata  <= 1'b0;
      end else if (i_tx_load) begin
         tx_sh    <= i_tx_byte;
         tx_cnt   <= 4'h8;
         tx_armed <= 1'b0;
         o_sdata  <= i_tx_byte[7];
      end else if (tx_cnt != 4'h0) begin
         if (clk_rise)
            tx_armed <= 1'b1;
         if (clk_fall && tx_armed) begin
            tx_sh  <= {tx_sh[6:0], 1'b0};
            tx_cnt <= tx_cnt - 4'h1;
            o_sdata <= tx_sh[6];
         end
      end
   end
   assign o_sdata_oe = (tx_cnt != 4'h0) && i_enable;

   default clocking lcb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   rx_one_pulse_a: assert property (
      o_rx_valid |=> !o_rx_valid)
      else $error("link byte strobe longer than one cycle");
   tx_starts_load_a: assert property (
      $rose(o_sdata_oe) |-> $past(i_tx_load))
      else $error("data pin driven without a loaded answer");
endmodule

// ### rtl/fsa_flash_ctrl.sv
// flash sector access and protection controller with axi4-lite registers
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module fsa_flash_ctrl
   import fsa_pkg::*;
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   // axi4-lite write
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // axi4-lite read
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // link pins
   input  wire logic        i_link_serial_clock_pin,
   input  wire logic        i_link_serial_data_pin,
   output logic             o_link_serial_data_pin,
   output logic             o_link_serial_data_pin_oe,
   input  wire logic        i_program_voltage_select_pin,
   input  wire logic        i_tool_attached,
   input  wire logic        i_tool_socket_mode,
   // status pins
   output logic             o_link_pins_reserved,
   output logic             o_in_circuit_comm_mode,
   output logic             o_readout_protect
);
   logic [7:0]  flash_mem [0:FSA_FLASH_BYTES-1];
   logic [2:0]  pin_s1;
   logic [2:0]  pin_s2;
   logic        aw_got;
   logic        w_got;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic [1:0]  ctrl_sel;
   logic [15:0] addr_reg;
   logic [7:0]  wdat;
   logic [7:0]  opt;
   logic        refused;
   fsa_state_t  state;
   logic [13:0] ers_cnt;
   logic [13:0] ers_end;
   logic        pend_opt;
   logic [7:0]  pend_val;
   logic [1:0]  lk_cnt;
   logic [7:0]  lk_cmd;
   logic [15:0] lk_addr;
   logic [7:0]  lk_data;
   logic        lk_fire;
   logic        lk_rd_pend;
   logic [7:0]  lk_rx;
   logic        lk_rx_valid;

   // pin synchronisers: voltage select, attach, socket strap
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
      end else begin
         pin_s1 <= {i_tool_socket_mode, i_tool_attached,
                    i_program_voltage_select_pin};
         pin_s2 <= pin_s1;
      end
   end
   wire sel_s    = pin_s2[0];
   wire attach_s = pin_s2[1];
   wire socket_s = pin_s2[2];
   // tool raises voltage select to enter the session; reset stays its own
   wire incirc   = sel_s && attach_s && !socket_s;
   wire app_mode = !socket_s && !incirc;
   wire [1:0] mode = socket_s ? FSA_MODE_SOCKET :
                     incirc ? FSA_MODE_INCIRC : FSA_MODE_APP;
   wire protect  = opt[FSA_OPT_PROT];
   wire busy     = (state != FSA_ENG_IDLE);
   assign o_link_pins_reserved   = attach_s;
   assign o_in_circuit_comm_mode = incirc;
   assign o_readout_protect      = protect;

   // axi write: address and data taken in either order, answer after both
   assign o_awready = !aw_got && !o_bvalid;
   assign o_wready  = !w_got && !o_bvalid;
   wire wr_fire  = aw_got && w_got;
   wire wr_ctrl  = wr_fire && (aw_addr == FSA_CTRL_OFS) && w_strb[0];
   wire wr_addr  = wr_fire && (aw_addr == FSA_ADDR_OFS);
   wire wr_wdat  = wr_fire && (aw_addr == FSA_WDATA_OFS) && w_strb[0];
   wire wr_stat  = wr_fire && (aw_addr == FSA_STAT_OFS) && w_strb[0];
   wire wr_hit   = (aw_addr == FSA_CTRL_OFS) || (aw_addr == FSA_ADDR_OFS) ||
                   (aw_addr == FSA_WDATA_OFS) || (aw_addr == FSA_RDATA_OFS) ||
                   (aw_addr == FSA_STAT_OFS) || (aw_addr == FSA_OPT_OFS);
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         aw_got   <= 1'b0;
         w_got    <= 1'b0;
         aw_addr  <= 8'h00;
         w_data   <= 32'h0000_0000;
         w_strb   <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp  <= FSA_RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_got  <= 1'b1;
            aw_addr <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_got  <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
         if (wr_fire) begin
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp  <= wr_hit ? FSA_RESP_OKAY : FSA_RESP_SLVERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // bus command: one start bit per write, lowest bit wins
   wire     bus_req = wr_ctrl && (w_data[FSA_CTRL_OPTW:FSA_CTRL_PROG] != 4'h0);
   fsa_op_t bus_op;
   assign bus_op = w_data[FSA_CTRL_PROG]   ? FSA_OP_PROG :
                   w_data[FSA_CTRL_SERASE] ? FSA_OP_SERASE :
                   w_data[FSA_CTRL_MERASE] ? FSA_OP_MERASE : FSA_OP_OPTW;
   wire [1:0] bus_sel = w_data[FSA_CTRL_SEL+1:FSA_CTRL_SEL];

   // link command decode, four bytes: command, address high, low, data
   fsa_op_t lk_op;
   assign lk_op = (lk_cmd == FSA_LK_PROG)   ? FSA_OP_PROG :
                  (lk_cmd == FSA_LK_SERASE) ? FSA_OP_SERASE :
                  (lk_cmd == FSA_LK_MERASE) ? FSA_OP_MERASE :
                  (lk_cmd == FSA_LK_OPTW)   ? FSA_OP_OPTW : FSA_OP_NONE;
   wire lk_req = lk_fire && (lk_op != FSA_OP_NONE);

   // a same-cycle clash of link and bus starts neither request; the clash sets refused
   wire         eng_req  = lk_req || bus_req;
   fsa_op_t     eng_op;
   assign eng_op = lk_req ? lk_op : bus_op;
   wire [15:0]  eng_addr = lk_req ? lk_addr : addr_reg;
   wire [7:0]   eng_data = lk_req ? lk_data : wdat;
   wire [1:0]   addr_sec = (eng_addr[15:12] == FSA_SEC0_TOP) ? 2'd0 :
                           (eng_addr[15:12] == FSA_SEC1_TOP) ? 2'd1 : 2'd2;
   wire [1:0]   eng_sec  = lk_req ? addr_sec : bus_sel;
   wire         in_range = (eng_addr >= FSA_FLASH_BASE);
   wire         sec_ok   = (32'(eng_sec) < FSA_SECTORS);
   wire [13:0]  eng_idx  = eng_addr[FSA_IDX_W-1:0];

   // permission: protection blocks program and erase, application mode spares sector 0
   wire op_allowed =
      (eng_op == FSA_OP_PROG)   ? (!protect && in_range &&
                                   !(app_mode && addr_sec == 2'd0)) :
      (eng_op == FSA_OP_SERASE) ? (!protect && sec_ok &&
                                   !(app_mode && eng_sec == 2'd0)) :
      (eng_op == FSA_OP_MERASE) ? (!protect && !app_mode) :
      (eng_op == FSA_OP_OPTW)   ? !app_mode : 1'b0;
   wire go        = eng_req && !busy && op_allowed && !(lk_req && bus_req);
   wire refuse    = (eng_req && !go) || (lk_req && bus_req);
   wire opt_clear = (eng_op == FSA_OP_OPTW) && protect && !eng_data[FSA_OPT_PROT];
   wire do_prog   = go && (eng_op == FSA_OP_PROG);
   wire do_erase  = go && ((eng_op == FSA_OP_SERASE) ||
                           (eng_op == FSA_OP_MERASE) || opt_clear);
   wire mass      = (eng_op != FSA_OP_SERASE);
   wire [13:0] ers_lo = mass ? 14'h0000 :
                        (eng_sec == 2'd0) ? FSA_S0_LO :
                        (eng_sec == 2'd1) ? FSA_S1_LO : FSA_S2_LO;
   wire [13:0] ers_hi = mass ? FSA_S0_HI :
                        (eng_sec == 2'd0) ? FSA_S0_HI :
                        (eng_sec == 2'd1) ? FSA_S1_HI : FSA_S2_HI;

   // engine: erase walks one byte per clock over the chosen range only
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         state    <= FSA_ENG_IDLE;
         ers_cnt  <= 14'h0000;
         ers_end  <= 14'h0000;
         pend_opt <= 1'b0;
         pend_val <= FSA_OPT_RST;
         opt      <= FSA_OPT_RST;
      end else begin
         case (state)
            FSA_ENG_IDLE: begin
               if (do_erase) begin
                  state    <= FSA_ENG_ERASE;
                  ers_cnt  <= ers_lo;
                  ers_end  <= ers_hi;
                  pend_opt <= opt_clear;
                  pend_val <= eng_data;
               end else if (go && eng_op == FSA_OP_OPTW) begin
                  opt <= eng_data;
               end
            end
            FSA_ENG_ERASE: begin
               ers_cnt <= ers_cnt + 14'h1;
               if (ers_cnt == ers_end) begin
                  state    <= FSA_ENG_IDLE;
                  pend_opt <= 1'b0;
                  if (pend_opt)
                     opt <= pend_val;
               end
            end
            default: state <= FSA_ENG_IDLE;
         endcase
      end
   end

   // single write port; the array is nonvolatile, so it takes no reset
   wire        mem_we  = do_prog || (state == FSA_ENG_ERASE);
   wire [13:0] mem_idx = (state == FSA_ENG_ERASE) ? ers_cnt : eng_idx;
   wire [7:0]  mem_wd  = (state == FSA_ENG_ERASE) ? FSA_ERASED : eng_data;
   always_ff @(posedge i_mclk) begin
      if (mem_we)
         flash_mem[mem_idx] <= mem_wd;
   end

   // registers; refused is sticky and a new refusal beats the clear
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         ctrl_sel <= FSA_CTRL_RST[FSA_CTRL_SEL+1:FSA_CTRL_SEL];
         addr_reg <= 16'h0000;
         wdat     <= 8'h00;
         refused  <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl_sel <= bus_sel;
         if (wr_addr && w_strb[0])
            addr_reg[7:0] <= w_data[7:0];
         if (wr_addr && w_strb[1])
            addr_reg[15:8] <= w_data[15:8];
         if (wr_wdat)
            wdat <= w_data[7:0];
         if (refuse)
            refused <= 1'b1;
         else if (wr_stat && w_data[FSA_STS_REFUSED])
            refused <= 1'b0;
      end
   end

   // axi read: one outstanding, answered the cycle after the address
   wire [7:0] ctrl_rd = {busy, 1'b0, ctrl_sel, 4'h0};
   wire [7:0] stat_rd = {3'h0, mode, protect, refused, busy};
   wire [7:0] mem_rd  = flash_mem[addr_reg[FSA_IDX_W-1:0]];
   wire       rd_hit  = (i_araddr == FSA_CTRL_OFS) || (i_araddr == FSA_ADDR_OFS) ||
                        (i_araddr == FSA_WDATA_OFS) || (i_araddr == FSA_RDATA_OFS) ||
                        (i_araddr == FSA_STAT_OFS) || (i_araddr == FSA_OPT_OFS);
   wire [15:0] rd_val =
      (i_araddr == FSA_CTRL_OFS)  ? {8'h00, ctrl_rd} :
      (i_araddr == FSA_ADDR_OFS)  ? addr_reg :
      (i_araddr == FSA_WDATA_OFS) ? {8'h00, wdat} :
      (i_araddr == FSA_RDATA_OFS) ? {8'h00, mem_rd} :
      (i_araddr == FSA_STAT_OFS)  ? {8'h00, stat_rd} :
      (i_araddr == FSA_OPT_OFS)   ? {8'h00, opt} : 16'h0000;
   assign o_arready = !o_rvalid;
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0000_0000;
         o_rresp  <= FSA_RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rdata  <= {16'h0000, rd_val};
         o_rresp  <= rd_hit ? FSA_RESP_OKAY : FSA_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

   // link framing restarts whenever the session is left
   always_ff @(posedge i_mclk) begin
      lk_fire    <= 1'b0;
      lk_rd_pend <= 1'b0;
      if (!i_reset_n || !incirc) begin
         lk_cnt  <= 2'h0;
         lk_cmd  <= 8'h00;
         lk_addr <= 16'h0000;
         lk_data <= 8'h00;
      end else if (lk_rx_valid) begin
         lk_cnt <= lk_cnt + 2'h1;
         case (lk_cnt)
            2'h0: lk_cmd <= lk_rx;
            2'h1: lk_addr[15:8] <= lk_rx;
            2'h2: begin
               lk_addr[7:0] <= lk_rx;
               lk_rd_pend   <= (lk_cmd == FSA_LK_READ);
            end
            default: begin
               lk_data <= lk_rx;
               lk_fire <= 1'b1;
            end
         endcase
      end
   end
   // protected array reads back as zero over the link
   wire [7:0] lk_tx = protect ? 8'h00 : flash_mem[lk_addr[FSA_IDX_W-1:0]];

   fsa_link_shifter u_link (
      .i_mclk      (i_mclk),
      .i_reset_n   (i_reset_n),
      .i_enable    (incirc),
      .i_sclk_pin  (i_link_serial_clock_pin),
      .i_sdata_pin (i_link_serial_data_pin),
      .o_sdata     (o_link_serial_data_pin),
      .o_sdata_oe  (o_link_serial_data_pin_oe),
      .i_tx_load   (lk_rd_pend),
      .i_tx_byte   (lk_tx),
      .o_rx_byte   (lk_rx),
      .o_rx_valid  (lk_rx_valid)
   );

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   sequence opt_clear_start;
      go && opt_clear;
   endsequence
   sequence erase_last_pending;
      state == FSA_ENG_ERASE && pend_opt && ers_cnt == ers_end;
   endsequence

   prot_blocks_write_a: assert property (
      (eng_req && protect && eng_op != FSA_OP_OPTW) |-> !go ##1 refused)
      else $error("write accepted while read-out protected");
   iap_sector0_a: assert property (
      (do_prog && app_mode) |-> addr_sec != 2'd0)
      else $error("sector 0 programmed in application mode");
   unprot_erase_a: assert property (
      opt_clear_start |=> state == FSA_ENG_ERASE && ers_cnt == 14'h0000 &&
                          ers_end == FSA_S0_HI && protect)
      else $error("protection lifted without a full erase");
   unprot_end_a: assert property (
      erase_last_pending |=> state == FSA_ENG_IDLE && !protect)
      else $error("protection not lifted after erase");
   erase_bounds_a: assert property (
      (state == FSA_ENG_ERASE) |-> mem_we && mem_wd == FSA_ERASED &&
                                 ers_cnt <= ers_end)
      else $error("erase walked outside its range");
   pins_reserved_a: assert property (
      o_link_serial_data_pin_oe |-> o_link_pins_reserved)
      else $error("data pin driven while tool absent");
   refuse_silent_a: assert property (
      (refuse && state == FSA_ENG_IDLE) |-> !mem_we ##1 state == FSA_ENG_IDLE)
      else $error("refused request changed the array");
   ctrl_reset_a: assert property (@(posedge i_mclk) disable iff (1'b0)
      !i_reset_n |=> ctrl_sel == 2'd0 && state == FSA_ENG_IDLE)
      else $error("control register not 00h after reset");
endmodule

// ### test/fsa_tool_model.sv
// tool model: clocks command frames into the device over the link
`timescale 1ns/1ps
module fsa_tool_model (
   // device drive in, tool clock and resolved wire out
   input  wire logic i_dev_d,
   input  wire logic i_dev_oe,
   output logic      o_sclk,
   output logic      o_wire
);
   logic d = 1'b0;
   logic oe = 1'b0;
   // a released wire flips from its last level so stale data never passes
   assign o_wire = i_dev_oe ? i_dev_d : (oe ? d : ~d);
   initial o_sclk = 1'b0;
   // clock rests low between frames; msb first, 160 ns per bit
   // the last eight bits seen on the wire come back as the answer byte;
   // the start sits off the core clock edge so no pin moves as it is sampled
   task automatic frame(input logic [31:0] f,
                        output logic [7:0] a);
      #2 oe = 1'b1;
      for (int i = 31; i >= 0; i--) begin
         d = f[i];
         #40 o_sclk = 1'b1;
         a = {a[6:0], o_wire};
         #80 o_sclk = 1'b0;
         #40;
      end
      oe = 1'b0;
   endtask
endmodule

// ### test/tb.sv
// bench: register bus tasks drive sector, protection and link tests
`timescale 1ns/1ps
module tb;
   import fsa_pkg::*;
   logic        clk = 0, rst_n = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0;
   logic        r_r = 0, att = 0, sock = 0, vsel = 0, aw_r, w_r, b_v, ar_r;
   logic        r_v, sclk, lvl, dd, doe, resv, incirc, prot;
   logic [7:0]  aw_a = 0, ar_a = 0, lrx;
   logic [31:0] wd = 0, rd_d, rdat;
   logic [1:0]  b_s, r_s, resp;
   int          num_errors = 0, n_compared = 0;
   always #5 clk = ~clk;
   fsa_flash_ctrl fsa_flash_ctrl_i (.i_mclk(clk), .i_reset_n(rst_n),
      .i_awaddr(aw_a), .i_awvalid(aw_v), .o_awready(aw_r), .i_wdata(wd),
      .i_wstrb(4'hF), .i_wvalid(w_v), .o_wready(w_r), .o_bresp(b_s),
      .o_bvalid(b_v), .i_bready(b_r), .i_araddr(ar_a), .i_arvalid(ar_v),
      .o_arready(ar_r), .o_rdata(rd_d), .o_rresp(r_s), .o_rvalid(r_v),
      .i_rready(r_r), .i_link_serial_clock_pin(sclk),
      .o_readout_protect(prot),
      .i_link_serial_data_pin(lvl), .o_link_serial_data_pin(dd),
      .o_link_serial_data_pin_oe(doe), .i_tool_socket_mode(sock),
      .i_program_voltage_select_pin(vsel), .i_tool_attached(att),
      .o_link_pins_reserved(resv), .o_in_circuit_comm_mode(incirc));
   fsa_tool_model fsa_tool_model_i (.i_dev_d(dd), .i_dev_oe(doe),
      .o_sclk(sclk), .o_wire(lvl));
   // ready is sampled mid-cycle so the release lands on the taking edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      logic ha, hw, fin;
      fin = 1'b0;
      {aw_a, ar_a, wd} <= {a, a, d};
      {aw_v, w_v, b_r, ar_v, r_r} <= {w, w, w, !w, !w};
      while (fin !== 1'b1) begin
         @(negedge clk);
         {ha, hw} = {(aw_v && aw_r) || (ar_v && ar_r), w_v && w_r};
         {fin, resp, rdat} = w ? {b_v, b_s, rd_d} : {r_v, r_s, rd_d};
         @(posedge clk);
         if (ha) {aw_v, ar_v} <= 2'b00;
         if (hw) w_v <= 1'b0;
      end
      {b_r, r_r} <= 2'b00;
      @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) num_errors++;
      if (g !== e) $display("FAIL at %0t got %h expected %h", $time, g, e);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
      bus(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask
   task automatic rb(input logic [7:0] e);
      rc(FSA_RDATA_OFS, 32'hFF, 32'(e));
   endtask
   // every write waits out busy, so no request is refused for overlap
   task automatic op(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      do bus(1'b0, FSA_STAT_OFS, 32'h0);
      while (rdat[FSA_STS_BUSY] !== 1'b0 && $time < 850_000);
   endtask
   task automatic prog(input logic [15:0] a, input logic [7:0] d);
      op(FSA_ADDR_OFS, 32'(a));
      op(FSA_WDATA_OFS, 32'(d));
      op(FSA_CTRL_OFS, 32'h01);
   endtask
   task automatic finish_test;
      $display("%0d compared, %0d mismatched", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #900_000 num_errors++;
      finish_test;
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rc(FSA_CTRL_OFS, 32'hFF, 32'h0);
      bus(1'b0, 8'h60, 32'h0);
      chk(32'(resp), 32'(FSA_RESP_SLVERR));
      $display("test reset done");
      op(FSA_CTRL_OFS, 32'h12);
      prog(16'hE010, 8'h5A);
      rb(8'h5A);
      op(FSA_CTRL_OFS, 32'h22);
      rb(8'h5A);
      prog(16'hF000, 8'h11);
      rc(FSA_STAT_OFS, 32'h1A, 32'h02);
      $display("test application done");
      {att, sock} <= 2'b11;
      repeat (4) @(posedge clk);
      chk(32'(resv), 32'h1);
      op(FSA_STAT_OFS, 32'h02);
      op(FSA_CTRL_OFS, 32'h02);
      prog(16'hF000, 8'h3C);
      rb(8'h3C);
      rc(FSA_STAT_OFS, 32'h1A, 32'h10);
      op(FSA_CTRL_OFS, 32'h32);
      rc(FSA_STAT_OFS, 32'h1A, 32'h12);
      op(FSA_WDATA_OFS, 32'h01);
      op(FSA_CTRL_OFS, 32'h08);
      rc(FSA_OPT_OFS, 32'h01, 32'h01);
      chk(32'(prot), 32'h1);
      prog(16'hE010, 8'h00);
      rb(8'h5A);
      // write data still holds 00h, so this option write lifts protection
      op(FSA_CTRL_OFS, 32'h08);
      rb(8'hFF);
      chk(32'(prot), 32'h0);
      $display("test protection done");
      {sock, vsel} <= 2'b01;
      repeat (4) @(posedge clk);
      chk(32'(incirc), 32'h1);
      // reset stays released while the tool runs its session
      fsa_tool_model_i.frame({FSA_LK_PROG, 24'hE030A5}, lrx);
      repeat (9) @(posedge clk);
      op(FSA_ADDR_OFS, 32'hE030);
      rb(8'hA5);
      fsa_tool_model_i.frame({FSA_LK_READ, 24'hE03000}, lrx);
      chk(32'(lrx), 32'hA5);
      @(posedge clk);
      fsa_tool_model_i.frame({FSA_LK_OPTW, 24'hE03001}, lrx);
      repeat (9) @(posedge clk);
      chk(32'(prot), 32'h1);
      fsa_tool_model_i.frame({FSA_LK_READ, 24'hE03000}, lrx);
      chk(32'(lrx), 32'h00);
      $display("test link done");
      finish_test;
   end
endmodule
